/* src/serial_host_port_spi_frame.sv */
/*
 Serial host port frame logic: shifts frames in on the serial clock, checks
 them, hands accepted reads and writes to the register map on clk, and
 shifts the answer frame out. Also steers the shared pins between the SPI
 and the UART break-mode path.
 Assumes: configuration bits and the answer data come from the register
 map on clk; chip select stays high for four clk cycles after a frame.
*/
// Summary of operation
// - Checked frame: command bit, 7-bit address, 16-bit data, 8-bit check byte.
// - Checking on after reset; with it off, frames are 24 bits.
// - Input bits are sampled on falling serial clock edges after select falls.
// - Select rising before a full frame discards it with no effect.
// - With extra edges, only the last 32 or 24 bits count.
// - A complete frame takes effect when select rises.
// - With select high and no break mode, clock and input are ignored, output floats.
// - Extra clocks output the input bits delayed by one frame length.
// - Read command returns the register value, MSB first, in the next frame.
// - Write command answer carries status, data 0x0000 and check byte.
// - Output driven with select low and readback enabled, or by the interrupt in break mode.
// - MSB at select fall, later bits on rising or falling edges by setting.
// - Answer starts with previous command bit then seven status bits.
// - Check error status bit reports a bad previous frame.
// - Works in clock mode 1 and clock mode 2.
// - Continuous or gated serial clock up to 12.5 MHz is accepted.
// - SPI cannot reach the break-mode control register.
// - In SPI operation the UART transmit pin can carry the interrupt.
// - UART at 9600 baud after power-up; reset clears break-mode register.
// - Break-mode access bit locks SPI out of the register map.
// - In break mode, SPI output carries interrupt, SPI input the clear.
// - Check byte polynomial x^8+x^2+x+1 over 24 bits.
// - A frame failing its check executes neither write nor read.
// - An all-zero 24-bit frame is the no-operation frame.
// - UART characters: start, eight data, odd parity, stop.
`timescale 1ns/1ps
`include "spi_frame_params.svh"

module serial_host_port_spi_frame (
   // Clock and reset
   input  wire logic                 clk,
   input  wire logic                 rstn,
   // Link pins
   input  wire logic                 sclk,
   input  wire logic                 chipSelN,
   input  wire logic                 serialInPin,
   output logic                      sdoOut,
   output logic                      sdoOeN,
   output logic                      uartTxPin,
   // Configuration bits
   input  wire logic                 crcEnable,
   input  wire logic                 readbackOutputOff,
   input  wire logic                 outputLaunchFalling,
   input  wire logic                 uartPathOff,
   input  wire logic                 irqPinSelect,
   input  wire logic                 clearPinSelect,
   // Break-mode control from the UART path
   input  wire logic                 ubmWrStb,
   input  wire logic                 ubmRegAccess,
   output logic                      breakModeLink,
   // Register map side
   output logic                      regWrStb,
   output logic                      regRdStb,
   output spi_frame_pkg::addr_t      regAddr,
   output spi_frame_pkg::word_t      regWrData,
   input  spi_frame_pkg::word_t      regRdData,
   input  wire logic [6:0]           statusIn,
   input  wire logic                 irqIn,
   input  wire logic                 uartTxData,
   output logic                      clearReq,
   output logic                      frameCrcErr
);

   // Check byte over 24 bits, MSB first, zero start value
   function automatic logic [7:0] crc8(input logic [23:0] d);
      logic [7:0] c;
      c = 8'h00;
      for (int i = 23; i >= 0; i--) begin
         c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? `CRC_POLY : 8'h00);
      end
      return c;
   endfunction

   // Bit to launch at a position: answer bit, or the delayed input bit
   function automatic logic pickBit(input logic [5:0] idx, input logic [5:0] len,
                                    input logic [31:0] resp, input logic late);
      return (idx < len) ? resp[~idx[4:0]] : late;
   endfunction

   // Link domain state
   logic        start_q;
   logic [31:0] rxShift_q;
   logic [5:0]  rxCount_q;
   logic        sdoFall_q;
   logic        sdoRise_q;
   // Clk domain state
   logic        csMeta_q, csSync_q, csPrev_q;
   logic        sdiMeta_q, sdiSync_q;
   logic [31:0] resp_q;
   logic        pendUpd_q, pendCmd_q, pendCrcErr_q;
   logic        breakMode_q;
   logic        wrStb_q, rdStb_q;
   spi_frame_pkg::addr_t addr_q;
   spi_frame_pkg::word_t wrData_q;
   logic        uartTx_q, clear_q, irq_q, crcErr_q;

   // Frame length follows the checking setting
   wire [5:0]  frameLen  = crcEnable ? `FRAME_LEN_CRC : `FRAME_LEN_PLAIN;
   wire [5:0]  countNext = (rxCount_q >= `COUNT_SAT) ? `COUNT_SAT : rxCount_q + 6'h01;
   wire [5:0]  fallIdx   = start_q ? 6'h01 : countNext;
   wire [5:0]  riseIdx   = start_q ? 6'h00 : rxCount_q;
   wire        lateRise  = crcEnable ? rxShift_q[31] : rxShift_q[23];
   wire        lateFall  = crcEnable ? rxShift_q[30] : rxShift_q[22];

   // Frame start flag: held set while select is high
   always_ff @(negedge sclk or posedge chipSelN or negedge rstn) begin
      if (!rstn) begin
         start_q <= 1'b1;
      end else if (chipSelN) begin
         start_q <= 1'b1;
      end else begin
         start_q <= 1'b0;
      end
   end

   // Input shift on falling edges; the low bits always hold the latest frame
   always_ff @(negedge sclk or negedge rstn) begin
      if (!rstn) begin
         rxShift_q <= 32'h00000000;
         rxCount_q <= 6'h00;
         sdoFall_q <= 1'b0;
      end else if (!chipSelN) begin
         rxShift_q <= {rxShift_q[30:0], serialInPin};
         rxCount_q <= start_q ? 6'h01 : countNext;
         sdoFall_q <= pickBit(fallIdx, frameLen, resp_q, lateFall);
      end
   end

   // Output launch on rising edges
   always_ff @(posedge sclk or negedge rstn) begin
      if (!rstn) begin
         sdoRise_q <= 1'b0;
      end else if (!chipSelN) begin
         sdoRise_q <= pickBit(riseIdx, frameLen, resp_q, lateRise);
      end
   end

   // Select synchroniser and rising edge detect
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         csMeta_q <= 1'b1;
         csSync_q <= 1'b1;
         csPrev_q <= 1'b1;
      end else begin
         csMeta_q <= chipSelN;
         csSync_q <= csMeta_q;
         csPrev_q <= csSync_q;
      end
   end

   // Frame decode on the clk side; link state is still while select is high
   wire        csRise    = csSync_q & ~csPrev_q;
   wire        frameFull = rxCount_q >= frameLen;
   wire [23:0] frame24   = crcEnable ? rxShift_q[31:8] : rxShift_q[23:0];
   wire        crcBad    = crcEnable & (crc8(frame24) != rxShift_q[7:0]);
   wire        frameCmd  = frame24[23];
   wire [6:0]  frameAddr = frame24[22:16];
   wire        isNop     = frame24 == `NOP_PATTERN;
   wire        mapOpen   = ~breakMode_q & (frameAddr != `BREAK_REG_ADDR);
   wire        frameTake = csRise & frameFull;
   wire        execOk    = frameTake & ~crcBad & mapOpen;
   wire        doWrite   = execOk & (frameCmd == spi_frame_pkg::CMD_WRITE) & ~isNop;
   wire        doRead    = execOk & (frameCmd == spi_frame_pkg::CMD_READ);

   // Register map strobes and captured frame fields
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wrStb_q      <= 1'b0;
         rdStb_q      <= 1'b0;
         addr_q       <= 7'h00;
         wrData_q     <= 16'h0000;
         pendUpd_q    <= 1'b0;
         pendCmd_q    <= 1'b0;
         pendCrcErr_q <= 1'b0;
      end else begin
         wrStb_q   <= doWrite;
         rdStb_q   <= doRead;
         pendUpd_q <= frameTake;
         if (frameTake) begin
            addr_q       <= frameAddr;
            wrData_q     <= frame24[15:0];
            pendCmd_q    <= frameCmd;
            pendCrcErr_q <= crcBad;
         end
      end
   end

   // Answer frame: command, status with check flag, data, check byte
   wire [6:0]  statusMerged = {statusIn[6:`STATUS_CRC_POS+1], pendCrcErr_q,
                               statusIn[`STATUS_CRC_POS-1:0]};
   wire [15:0] respData = rdStb_q ? regRdData : 16'h0000;
   wire [23:0] resp24   = {pendCmd_q, statusMerged, respData};

   // Answer register, read by the link logic only while select is low
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         resp_q   <= `RESP_RESET;
         crcErr_q <= 1'b0;
      end else if (pendUpd_q) begin
         resp_q   <= {resp24, crc8(resp24)};
         crcErr_q <= pendCrcErr_q;
      end
   end

   // Break-mode control register, written only from the UART path
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         breakMode_q <= 1'b0;
      end else if (ubmWrStb) begin
         breakMode_q <= ubmRegAccess;
      end
   end

   // Clear pin input synchroniser
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sdiMeta_q <= 1'b0;
         sdiSync_q <= 1'b0;
      end else begin
         sdiMeta_q <= serialInPin;
         sdiSync_q <= sdiMeta_q;
      end
   end

   // Shared pin functions
   wire irqOnUart = uartPathOff & irqPinSelect & ~breakMode_q;
   wire irqOnSdo  = breakMode_q & irqPinSelect;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         uartTx_q <= 1'b1;
         clear_q  <= 1'b0;
         irq_q    <= 1'b0;
      end else begin
         uartTx_q <= irqOnUart ? irqIn : uartTxData;
         clear_q  <= breakMode_q & clearPinSelect & sdiSync_q;
         irq_q    <= irqIn;
      end
   end

   // Serial output: MSB while no falling edge has come, then the selected launch edge
   wire spiBit = start_q ? resp_q[31] : (outputLaunchFalling ? sdoFall_q : sdoRise_q);
   assign sdoOut = irqOnSdo ? irq_q : spiBit;
   assign sdoOeN = irqOnSdo ? 1'b0 : (chipSelN | readbackOutputOff);

   // Register-side outputs
   assign regWrStb      = wrStb_q;
   assign regRdStb      = rdStb_q;
   assign regAddr       = addr_q;
   assign regWrData     = wrData_q;
   assign uartTxPin     = uartTx_q;
   assign clearReq      = clear_q;
   assign breakModeLink = breakMode_q;
   assign frameCrcErr   = crcErr_q;

   // Short frames touch nothing
   property p_short_discard;
      @(posedge clk) disable iff (!rstn)
      (csRise && !frameFull) |=> (!regWrStb && !regRdStb);
   endproperty
   a_short_discard: assert property (p_short_discard)
      else $error("short frame caused a register access");

   // Bad check byte blocks execution and is reported
   property p_crc_block;
      @(posedge clk) disable iff (!rstn)
      (frameTake && crcBad) |=> (!regWrStb && !regRdStb) ##1 resp_q[`STATUS_CRC_POS+24];
   endproperty
   a_crc_block: assert property (p_crc_block)
      else $error("bad frame executed or not flagged");

   // Good frame clears the check flag in the answer
   property p_crc_clear;
      @(posedge clk) disable iff (!rstn)
      (frameTake && !crcBad) |-> ##2 !resp_q[`STATUS_CRC_POS+24];
   endproperty
   a_crc_clear: assert property (p_crc_clear)
      else $error("check flag set after good frame");

   // Write answer carries zero data
   property p_write_zero;
      @(posedge clk) disable iff (!rstn)
      regWrStb |=> (resp_q[23:8] == 16'h0000) && (resp_q[31] == 1'b0);
   endproperty
   a_write_zero: assert property (p_write_zero)
      else $error("write answer data not zero");

   // Read answer carries the register value
   property p_read_data;
      @(posedge clk) disable iff (!rstn)
      regRdStb |=> (resp_q[23:8] == $past(regRdData)) && resp_q[31];
   endproperty
   a_read_data: assert property (p_read_data)
      else $error("read answer data wrong");

   // Break-mode register never reached over SPI
   property p_no_break_reg;
      @(posedge clk) disable iff (!rstn)
      (regWrStb || regRdStb) |-> (regAddr != `BREAK_REG_ADDR);
   endproperty
   a_no_break_reg: assert property (p_no_break_reg)
      else $error("SPI accessed break-mode register");

   // Break mode locks SPI out
   property p_lockout;
      @(posedge clk) disable iff (!rstn)
      $past(breakMode_q) |-> (!regWrStb && !regRdStb);
   endproperty
   a_lockout: assert property (p_lockout)
      else $error("SPI access while in break mode");

   // Write strobes follow a synchronised select rise by one cycle
   property p_commit_edge;
      @(posedge clk) disable iff (!rstn)
      regWrStb |-> $past(csSync_q) && !$past(csPrev_q);
   endproperty
   a_commit_edge: assert property (p_commit_edge)
      else $error("access not tied to select rise");

   // UART transmit pin follows the interrupt in SPI operation
   property p_uart_irq;
      @(posedge clk) disable iff (!rstn)
      irqOnUart |=> (uartTxPin == $past(irqIn));
   endproperty
   a_uart_irq: assert property (p_uart_irq)
      else $error("UART pin not carrying interrupt");

   // Output floats while the select pin is high outside break-mode interrupt use
   property p_float;
      @(posedge clk) disable iff (!rstn)
      (chipSelN && !irqOnSdo) |-> sdoOeN;
   endproperty
   a_float: assert property (p_float)
      else $error("serial output driven with select high");

endmodule // serial_host_port_spi_frame

/* src/spi_frame_params.svh */
/*
 Constants of the serial host port frame logic: frame lengths, check byte
 polynomial, reserved address of the break-mode control register, status
 layout and timing figures. Assumes inclusion by bare name from src/.
*/
`ifndef SPI_FRAME_PARAMS_SVH
`define SPI_FRAME_PARAMS_SVH

// Frame lengths in bits, with and without the check byte
`define FRAME_LEN_CRC    6'h20
`define FRAME_LEN_PLAIN  6'h18
// Receive bit counter stops here, well past any frame length
`define COUNT_SAT        6'h30
// Check byte polynomial x^8+x^2+x+1 without its top term
`define CRC_POLY         8'h07
// All-zero command, address and data collects a pending answer
`define NOP_PATTERN      24'h000000
// Address of the break-mode control register
`define BREAK_REG_ADDR   7'h7f
// Position of the frame check error flag among the seven status bits
`define STATUS_CRC_POS   5
// Reset value of the answer frame
`define RESP_RESET       32'h00000000
// UART rate after power-up and the internal clock rate
`define UART_BAUD        9600
`define CLK_HZ           20000000

`endif

/* src/spi_frame_pkg.sv */
/*
 Types shared by the serial host port frame logic.
 Assumes the constants header is compiled alongside.
*/
package spi_frame_pkg;

   // Register address and data word
   typedef logic [6:0]  addr_t;
   typedef logic [15:0] word_t;

   // Command bit at the head of each frame
   typedef enum logic {
      CMD_WRITE = 1'b0,
      CMD_READ  = 1'b1
   } cmd_t;

endpackage

/* tb/spi_host_model.sv */
/*
 Host side of the serial link: makes frames on sclk, chipSelN and
 serialInPin and collects the answer bits. Assumes a 48 ns link clock.
*/
`timescale 1ns/1ps
module spi_host_model (
   // Link pins
   output logic      sclk,
   output logic      chipSelN,
   output logic      serialInPin,
   input  wire logic sdoOut,
   input  wire logic sdoOeN
);
   logic idleHigh;

   // Idle level of the clock: low for mode 1, high for mode 2
   task automatic mode(input logic h);
      idleHigh = h;
      sclk = h;
   endtask

   // Clock runs only inside the frame; bits set on rising, taken on falling
   task automatic frame(input logic [47:0] din, input int n, output logic [47:0] dout);
      dout = '0;
      serialInPin = din[n-1];
      chipSelN = 1'b0;
      #24;
      for (int i = 0; i < n; i++) begin
         sclk = 1'b1;
         serialInPin = din[n-1-i];
         #24;
         dout = {dout[46:0], sdoOeN ? 1'bz : sdoOut};
         sclk = 1'b0;
         #24;
      end
      sclk = idleHigh;
      #24;
      chipSelN = 1'b1;
      serialInPin = ~serialInPin; // Released line shows no stale value
   endtask

   initial begin
      sclk = 1'b0;
      chipSelN = 1'b1;
      serialInPin = 1'b0;
      idleHigh = 1'b0;
   end
endmodule // spi_host_model

/* tb/tb_serial_host_port_spi_frame.sv */
/*
 Self-checking bench of the serial host port frame logic.
 Assumes the host model drives the link and the bench acts as register map.
*/
`timescale 1ns/1ps
`define CHECK(what, exp, got) begin \
   comparisons++; \
   if ((got) !== (exp)) begin \
      errTotal++; \
      $display("[FAIL] %s expected %h seen %h", what, exp, got); \
   end \
end
module tb_serial_host_port_spi_frame;
   logic                 clk, rstn, sclk, chipSelN, serialInPin, sdoOut, sdoOeN, uartTxPin;
   logic                 crcEnable, readbackOutputOff, outputLaunchFalling, uartPathOff;
   logic                 irqPinSelect, clearPinSelect, ubmWrStb, ubmRegAccess, breakModeLink;
   logic                 regWrStb, regRdStb, irqIn, uartTxData, clearReq, frameCrcErr;
   logic [6:0]           statusIn;
   logic [47:0]          dout;
   spi_frame_pkg::addr_t regAddr;
   spi_frame_pkg::word_t regWrData, regRdData;
   int                   errTotal, comparisons, wrCount, rdCount, cycles;

   serial_host_port_spi_frame i_serial_host_port_spi_frame (.clk(clk), .rstn(rstn),
      .sclk(sclk), .chipSelN(chipSelN), .serialInPin(serialInPin), .sdoOut(sdoOut),
      .sdoOeN(sdoOeN), .uartTxPin(uartTxPin), .crcEnable(crcEnable),
      .readbackOutputOff(readbackOutputOff), .outputLaunchFalling(outputLaunchFalling),
      .uartPathOff(uartPathOff), .irqPinSelect(irqPinSelect), .clearPinSelect(clearPinSelect),
      .ubmWrStb(ubmWrStb), .ubmRegAccess(ubmRegAccess), .breakModeLink(breakModeLink),
      .regWrStb(regWrStb), .regRdStb(regRdStb), .regAddr(regAddr), .regWrData(regWrData),
      .regRdData(regRdData), .statusIn(statusIn), .irqIn(irqIn), .uartTxData(uartTxData),
      .clearReq(clearReq), .frameCrcErr(frameCrcErr));
   spi_host_model i_spi_host_model (.sclk(sclk), .chipSelN(chipSelN),
      .serialInPin(serialInPin), .sdoOut(sdoOut), .sdoOeN(sdoOeN));

   // Register map stand-in: read value derived from the address
   assign regRdData = {regAddr, regAddr, 2'h3};

   always #25 clk = ~clk;

   // Strobe counting and hang guard
   always @(posedge clk) begin
      wrCount += (regWrStb === 1'b1);
      rdCount += (regRdStb === 1'b1);
      cycles++;
      if (cycles == 20000) begin
         errTotal++;
         stopTest();
      end
   end

   task automatic tick();
      @(posedge clk);
      #1;
   endtask

   function automatic logic [7:0] crc8(input logic [23:0] d);
      logic [7:0] c;
      c = 8'h00;
      for (int i = 23; i >= 0; i--)
         c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
      return c;
   endfunction

   // Expected answer: previous command, status with check flag, data, check byte
   function automatic logic [31:0] ans(input logic cmd, input logic err, input logic [15:0] d);
      logic [23:0] a;
      a = {cmd, statusIn[6], err, statusIn[4:0], d};
      return {a, crc8(a)};
   endfunction

   // One frame; two marker bits sit just ahead of it for long frames
   task automatic send(input logic cmd, input logic [6:0] a, input logic [15:0] d,
                       input int n, input logic bad);
      logic [23:0] f;
      logic [47:0] din;
      f = {cmd, a, d};
      din = crcEnable ? {16'h0002, f, crc8(f) ^ {7'h0, bad}} : {22'h0, 2'h2, f};
      i_spi_host_model.frame(din, n, dout);
      repeat (10) tick();
   endtask

   task automatic stopTest();
      $display("comparisons %0d mismatches %0d", comparisons, errTotal);
      if (errTotal == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   initial begin
      {clk, rstn, outputLaunchFalling, irqPinSelect, clearPinSelect} = '0;
      {ubmWrStb, ubmRegAccess, irqIn, readbackOutputOff} = '0;
      {crcEnable, uartTxData} = 2'h3;
      uartPathOff = 1'b1;
      statusIn = 7'h35;
      repeat (20) tick();
      rstn = 1'b1;
      repeat (5) tick();
      `CHECK("idle oe", 1'b1, sdoOeN)
      send(1'b0, 7'h12, 16'hbeef, 32, 1'b0);
      `CHECK("wr count", 1, wrCount)
      `CHECK("wr addr", 7'h12, regAddr)
      `CHECK("wr data", 16'hbeef, regWrData)
      send(1'b0, 7'h00, 16'h0000, 32, 1'b0);
      `CHECK("nop no write", 1, wrCount)
      `CHECK("wr answer", ans(1'b0, 1'b0, 16'h0000), dout[31:0])
      $display("write test done");
      i_spi_host_model.mode(1'b1);
      send(1'b1, 7'h05, 16'hffff, 32, 1'b0);
      `CHECK("rd count", 1, rdCount)
      outputLaunchFalling = 1'b1;
      send(1'b0, 7'h00, 16'h0000, 32, 1'b0);
      `CHECK("rd answer", ans(1'b1, 1'b0, 16'h0a17), dout[31:0])
      outputLaunchFalling = 1'b0;
      i_spi_host_model.mode(1'b0);
      $display("read test done");
      send(1'b0, 7'h20, 16'h1234, 32, 1'b1);
      `CHECK("bad crc", 1, wrCount)
      `CHECK("crc flag", 1'b1, frameCrcErr)
      send(1'b0, 7'h00, 16'h0000, 32, 1'b0);
      `CHECK("bad answer", ans(1'b0, 1'b1, 16'h0000), dout[31:0])
      send(1'b0, 7'h21, 16'h5555, 20, 1'b0);
      `CHECK("short", 1, wrCount)
      send(1'b0, 7'h7f, 16'h5555, 32, 1'b0);
      `CHECK("break addr", 1, wrCount)
      $display("refusal test done");
      send(1'b0, 7'h44, 16'h0a0a, 34, 1'b0);
      `CHECK("long addr", 7'h44, regAddr)
      `CHECK("long echo", 2'h2, dout[1:0])
      crcEnable = 1'b0;
      send(1'b0, 7'h33, 16'h0f0f, 24, 1'b0);
      `CHECK("plain data", 16'h0f0f, regWrData)
      crcEnable = 1'b1;
      readbackOutputOff = 1'b1;
      send(1'b0, 7'h00, 16'h0000, 32, 1'b0);
      `CHECK("no readback", 1'bz, dout[31])
      readbackOutputOff = 1'b0;
      $display("frame length test done");
      irqPinSelect = 1'b1;
      repeat (3) tick();
      `CHECK("tx irq", 1'b0, uartTxPin)
      irqPinSelect = 1'b0;
      repeat (3) tick();
      `CHECK("tx data", 1'b1, uartTxPin)
      {ubmWrStb, ubmRegAccess} = 2'h3;
      tick();
      ubmWrStb = 1'b0;
      tick();
      `CHECK("break on", 1'b1, breakModeLink)
      send(1'b0, 7'h10, 16'h7777, 32, 1'b0);
      `CHECK("spi locked", 3, wrCount)
      {irqPinSelect, clearPinSelect, irqIn} = 3'h7;
      i_spi_host_model.serialInPin = 1'b1;
      repeat (6) tick();
      `CHECK("sdo irq oe", 1'b0, sdoOeN)
      `CHECK("sdo irq", 1'b1, sdoOut)
      `CHECK("clear req", 1'b1, clearReq)
      rstn = 1'b0;
      repeat (3) tick();
      `CHECK("break reset", 1'b0, breakModeLink)
      rstn = 1'b1;
      $display("pin steering test done");
      stopTest();
   end
endmodule // tb_serial_host_port_spi_frame
